// [core/sepc_ctrl.sv]
`timescale 1ns/1ps
module sepc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [CW-1:0]               count;
  } sepc_fifo_t;
  sepc_fifo_t r_r;
  sepc_fifo_t r_nxt;
  logic       push;
  logic       pop;
  assign inReady = r_r.count != CW'(DEPTH);
  assign outValid = r_r.count != '0;
  assign outData = r_r.mem[r_r.rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  always_comb begin
    r_nxt = r_r;
    if (push) begin
      r_nxt.mem[r_r.wrPtr] = inData;
      r_nxt.wrPtr = (r_r.wrPtr == PW'(DEPTH - 1)) ? '0 : r_r.wrPtr + 1'b1;
    end
    if (pop) begin
      r_nxt.rdPtr = (r_r.rdPtr == PW'(DEPTH - 1)) ? '0 : r_r.rdPtr + 1'b1;
    end
    r_nxt.count = r_r.count + CW'(push) - CW'(pop);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule

// Overview of operation
// - Sample serial input on serial clock rise
// - Serial output changes after falling edges only
// - Deselected: output released, standby unless writing
// - Ignore everything until first select fall
// - Guard low with enable blocks status writes
// - Guard falling mid status command aborts it
// - Guard enable clear means pin ignored
// - Pause enters and leaves while clock low
// - Paused: inputs ignored, position kept
// - Eight-bit instruction register, MSB first
// - First bit on first rise; static clock
// - Writes complete only with latch set
// - Latch clears at power-up and write end
// - Status readable any time, even busy
// - Status layout: enable, locks, latch, busy
// - Latch and busy flags read-only
// - Busy reads all ones in status
// - Lock levels protect none, quarter, half, all
// - Protected bytes readable, never altered
// - Decode latch set, clear, status read
// - Decode status write, fetch, program
// - Write permission table for array, status
// - Fetch: 16-bit address, streaming, wrapping
// - Program wraps within its 32-byte page
// - Write starts only on byte boundary deselect
module sepc_ctrl
#(
  parameter int WRITE_CYCLES_P = sepc_pkg::WRITE_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       serialClock,
  input  wire logic                       selectN,
  input  wire logic                       serialIn,
  input  wire logic                       pauseN,
  input  wire logic                       writeGuardN,
  output logic                            serialOut,
  output logic                            serialOutEn,
  output logic [sepc_pkg::ADDR_W-1:0]     arrRdAddr,
  input  wire logic [7:0]                 arrRdData,
  output logic                            arrWrValid,
  input  wire logic                       arrWrReady,
  output logic [sepc_pkg::ADDR_W-1:0]     arrWrAddr,
  output logic [7:0]                      arrWrData,
  output logic                            writeBusy
);
  import sepc_pkg::*;
  typedef struct packed {
    logic [4:0]            pin1;
    logic [4:0]            pin2;
    logic                  sckPrev;
    logic                  selPrev;
    logic                  guardPrev;
    logic                  armed;
    logic                  paused;
    sepc_phase_t           phase;
    logic [7:0]            opcode;
    logic [4:0]            bitCnt;
    logic [15:0]           inShift;
    logic [2:0]            outCnt;
    logic [7:0]            outShift;
    logic                  so;
    logic                  soEn;
    logic [ADDR_W-1:0]     addr;
    logic                  byteDone;
    logic                  abortStat;
    logic [7:0]            statNew;
    logic                  latch;
    logic                  guardEn;
    logic [1:0]            lock;
    logic                  busy;
    logic [31:0]           timer;
    logic                  draining;
    logic [PAGE_W-1:0]     drainIdx;
    logic [ADDR_W-1:PAGE_W] pageHi;
    logic [31:0]           pageValid;
    logic [31:0][7:0]      pageBuf;
  } sepc_core_t;
  sepc_core_t          r_r;
  sepc_core_t          r_nxt;
  logic                sckNow;
  logic                selN;
  logic                siNow;
  logic                pauseNow;
  logic                guardNow;
  logic                sckRise;
  logic                sckFall;
  logic                selFall;
  logic                selRise;
  logic                guardFall;
  logic                active;
  logic                step;
  logic [7:0]          statusView;
  logic [7:0]          outByte;
  logic [ADDR_W-1:0]   drainAddr;
  logic                pushValid;
  logic                pushReady;
  logic                drainLocked;
  function automatic logic isLocked(input logic [1:0] lvl,
                                    input logic [ADDR_W-1:0] a);
    unique case (lvl)
      LOCK_NONE:    isLocked = 1'b0;
      LOCK_QUARTER: isLocked = a >= QUARTER_BASE;
      LOCK_HALF:    isLocked = a >= HALF_BASE;
      default:      isLocked = 1'b1;
    endcase
  endfunction
  function automatic sepc_phase_t decodeOp(input logic [7:0] op,
                                           input logic busy);
    decodeOp = PH_IGNORE;
    if (op == OP_READ_STAT) begin
      decodeOp = PH_STATRD;
    end else if (!busy && op == OP_WRITE_STAT) begin
      decodeOp = PH_STATWR;
    end else if (!busy && (op == OP_FETCH || op == OP_PROGRAM)) begin
      decodeOp = PH_ADDR;
    end
  endfunction
  assign sckNow = r_r.pin2[PIN_SCK];
  assign selN = r_r.pin2[PIN_SEL];
  assign siNow = r_r.pin2[PIN_SI];
  assign pauseNow = r_r.pin2[PIN_PAUSE];
  assign guardNow = r_r.pin2[PIN_GUARD];
  assign sckRise = sckNow & ~r_r.sckPrev;
  assign sckFall = ~sckNow & r_r.sckPrev;
  assign selFall = ~selN & r_r.selPrev;
  assign selRise = selN & ~r_r.selPrev;
  assign guardFall = ~guardNow & r_r.guardPrev;
  assign active = ~selN & r_r.armed;
  assign step = active & ~r_r.paused;
  assign statusView = r_r.busy ? ST_BUSY_VIEW :
    {r_r.guardEn, 3'b000, r_r.lock, r_r.latch, 1'b0};
  assign outByte = (r_r.phase == PH_FETCH) ? arrRdData : statusView;
  assign drainAddr = {r_r.pageHi, r_r.drainIdx};
  assign drainLocked = isLocked(r_r.lock, drainAddr);
  assign serialOut = r_r.so;
  assign serialOutEn = r_r.soEn;
  assign arrRdAddr = r_r.addr;
  assign writeBusy = r_r.busy;
  sepc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({drainAddr, r_r.pageBuf[r_r.drainIdx]}),
    .outValid (arrWrValid),
    .outReady (arrWrReady),
    .outData  ({arrWrAddr, arrWrData})
  );
  always_comb begin
    r_nxt = r_r;
    pushValid = 1'b0;
    r_nxt.pin1 = {writeGuardN, pauseN, serialIn, selectN, serialClock};
    r_nxt.pin2 = r_r.pin1;
    r_nxt.sckPrev = sckNow;
    r_nxt.selPrev = selN;
    r_nxt.guardPrev = guardNow;
    r_nxt.soEn = step;
    if (selFall) begin
      r_nxt.armed = 1'b1;
      r_nxt.phase = PH_OPCODE;
      r_nxt.bitCnt = '0;
      r_nxt.byteDone = 1'b0;
      r_nxt.abortStat = 1'b0;
    end
    // Pause only changes while the serial clock is low
    if (active && !sckNow) begin
      r_nxt.paused = ~pauseNow;
    end
    if (step && sckRise) begin
      r_nxt.inShift = {r_r.inShift[14:0], siNow};
      r_nxt.bitCnt = r_r.bitCnt + 5'h01;
      r_nxt.byteDone = 1'b0;
      unique case (r_r.phase)
        PH_OPCODE: begin
          if (r_r.bitCnt == LAST_BYTE_BIT) begin
            r_nxt.bitCnt = '0;
            r_nxt.outCnt = '0;
            r_nxt.opcode = r_nxt.inShift[7:0];
            r_nxt.phase = decodeOp(r_nxt.inShift[7:0], r_r.busy);
            if (!r_r.busy && r_nxt.opcode == OP_SET_LATCH) begin
              r_nxt.latch = 1'b1;
            end
            if (!r_r.busy && r_nxt.opcode == OP_CLR_LATCH) begin
              r_nxt.latch = 1'b0;
            end
          end
        end
        PH_ADDR: begin
          if (r_r.bitCnt == LAST_ADDR_BIT) begin
            r_nxt.bitCnt = '0;
            r_nxt.outCnt = '0;
            r_nxt.addr = r_nxt.inShift[ADDR_W-1:0];
            if (r_r.opcode == OP_FETCH) begin
              r_nxt.phase = PH_FETCH;
            end else begin
              r_nxt.phase = PH_PROGRAM;
              r_nxt.pageValid = '0;
            end
          end
        end
        PH_PROGRAM: begin
          if (r_r.bitCnt == LAST_BYTE_BIT) begin
            r_nxt.bitCnt = '0;
            r_nxt.pageBuf[r_r.addr[PAGE_W-1:0]] = r_nxt.inShift[7:0];
            r_nxt.pageValid[r_r.addr[PAGE_W-1:0]] = 1'b1;
            r_nxt.addr[PAGE_W-1:0] = r_r.addr[PAGE_W-1:0] + 5'h01;
            r_nxt.byteDone = 1'b1;
          end
        end
        PH_STATWR: begin
          if (r_r.bitCnt == LAST_BYTE_BIT) begin
            r_nxt.bitCnt = '0;
            r_nxt.statNew = r_nxt.inShift[7:0];
            r_nxt.byteDone = 1'b1;
          end
        end
        PH_FETCH: begin
          if (r_r.bitCnt == LAST_BYTE_BIT) begin
            r_nxt.bitCnt = '0;
            r_nxt.addr = r_r.addr + 12'h001;
          end
        end
        PH_STATRD: begin
          if (r_r.bitCnt == LAST_BYTE_BIT) begin
            r_nxt.bitCnt = '0;
          end
        end
        default: begin
          r_nxt.bitCnt = r_r.bitCnt;
        end
      endcase
    end
    // Read data leaves after each falling edge
    if (step && sckFall &&
        (r_r.phase == PH_FETCH || r_r.phase == PH_STATRD)) begin
      if (r_r.outCnt == 3'h0) begin
        r_nxt.so = outByte[7];
        r_nxt.outShift = {outByte[6:0], 1'b0};
      end else begin
        r_nxt.so = r_r.outShift[7];
        r_nxt.outShift = {r_r.outShift[6:0], 1'b0};
      end
      r_nxt.outCnt = r_r.outCnt + 3'h1;
    end
    if (active && guardFall && r_r.guardEn && r_r.phase == PH_STATWR) begin
      r_nxt.abortStat = 1'b1;
    end
    if (selRise) begin
      r_nxt.phase = PH_IDLE;
      r_nxt.paused = 1'b0;
      if (r_r.phase == PH_PROGRAM && r_r.byteDone &&
          r_r.latch && !r_r.busy) begin
        r_nxt.busy = 1'b1;
        r_nxt.timer = '0;
        r_nxt.draining = 1'b1;
        r_nxt.drainIdx = '0;
        r_nxt.pageHi = r_r.addr[ADDR_W-1:PAGE_W];
      end
      if (r_r.phase == PH_STATWR && r_r.byteDone && r_r.latch &&
          !r_r.busy && !r_r.abortStat &&
          !(r_r.guardEn && !guardNow)) begin
        r_nxt.guardEn = r_r.statNew[ST_GUARD_EN];
        r_nxt.lock = {r_r.statNew[ST_LOCK_HI], r_r.statNew[ST_LOCK_LO]};
        r_nxt.busy = 1'b1;
        r_nxt.timer = '0;
      end
    end
    // Hand unprotected page bytes to the array queue
    if (r_r.draining) begin
      if (r_r.pageValid[r_r.drainIdx] && !drainLocked) begin
        pushValid = 1'b1;
      end
      if (!pushValid || pushReady) begin
        r_nxt.drainIdx = r_r.drainIdx + 5'h01;
        if (r_r.drainIdx == LAST_PAGE_IDX) begin
          r_nxt.draining = 1'b0;
        end
      end
    end
    if (r_r.busy) begin
      if (r_r.timer != 32'(WRITE_CYCLES_P - 1)) begin
        r_nxt.timer = r_r.timer + 32'h1;
      end else if (!r_r.draining && !arrWrValid) begin
        r_nxt.busy = 1'b0;
        r_nxt.latch = 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence writeEnd;
    r_r.busy ##1 !r_r.busy;
  endsequence
  sequence guardedCommit;
    selRise && r_r.phase == PH_STATWR && r_r.guardEn && !guardNow;
  endsequence
  so_high_z_a: assert property (selN |=> !serialOutEn)
    else $error("serial output driven while deselected");
  so_on_fall_a: assert property ($changed(serialOut) |->
    $past(sckFall))
    else $error("serial output changed without falling edge");
  arm_gate_a: assert property ((!r_r.armed && !selFall) |=>
    r_r.phase == PH_IDLE)
    else $error("operation accepted before select fall");
  guard_block_a: assert property (guardedCommit |=>
    !r_r.busy && $stable(r_r.lock))
    else $error("status written while guard active");
  abort_stat_a: assert property ((selRise && r_r.abortStat &&
    r_r.phase == PH_STATWR) |=> !r_r.busy)
    else $error("aborted status write started");
  pause_hold_a: assert property ((r_r.paused && !selN) |=>
    $stable(r_r.bitCnt) && $stable(r_r.phase))
    else $error("sequence moved while paused");
  latch_end_a: assert property (writeEnd |-> !r_r.latch)
    else $error("latch still set after write cycle");
  busy_len_a: assert property ($fell(r_r.busy) |->
    $past(r_r.timer) == 32'(WRITE_CYCLES_P - 1))
    else $error("write cycle length wrong");
  busy_view_a: assert property ((step && sckFall && r_r.busy &&
    r_r.phase == PH_STATRD && r_r.outCnt == 3'h0) |=> serialOut)
    else $error("busy status bit not read as one");
  protect_a: assert property (pushValid |-> (r_r.lock == LOCK_NONE ||
    (r_r.lock == LOCK_QUARTER && drainAddr[ADDR_W-1:ADDR_W-2] != 2'h3) ||
    (r_r.lock == LOCK_HALF && !drainAddr[ADDR_W-1])))
    else $error("protected byte sent to array");
  page_wrap_a: assert property ((step && sckRise &&
    r_r.phase == PH_PROGRAM && r_r.bitCnt == LAST_BYTE_BIT) |=>
    r_r.addr[ADDR_W-1:PAGE_W] == $past(r_r.addr[ADDR_W-1:PAGE_W]))
    else $error("program address left its page");
endmodule

// [core/sepc_pkg.sv]
package sepc_pkg;
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 5;
  localparam int WORD_W = ADDR_W + 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_US = 1000;
  localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STAT = 8'h05;
  localparam logic [7:0] OP_WRITE_STAT = 8'h01;
  localparam logic [7:0] OP_FETCH = 8'h03;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam int ST_GUARD_EN = 7;
  localparam int ST_LOCK_HI = 3;
  localparam int ST_LOCK_LO = 2;
  localparam logic [7:0] ST_BUSY_VIEW = 8'hFF;
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_QUARTER = 2'h1;
  localparam logic [1:0] LOCK_HALF = 2'h2;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 12'hC00;
  localparam logic [ADDR_W-1:0] HALF_BASE = 12'h800;
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h0F;
  localparam logic [PAGE_W-1:0] LAST_PAGE_IDX = 5'h1F;
  localparam int PIN_SCK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_PAUSE = 3;
  localparam int PIN_GUARD = 4;
  typedef enum logic [2:0] {
    PH_IDLE, PH_OPCODE, PH_ADDR, PH_FETCH,
    PH_PROGRAM, PH_STATWR, PH_STATRD, PH_IGNORE
  } sepc_phase_t;
endpackage

// [sim/sepc_spi_master.sv]
`timescale 1ns/1ps
module sepc_spi_master (
  input  wire logic clk,
  input  wire logic serialOut,
  input  wire logic serialOutEn,
  output logic      serialClock,
  output logic      selectN,
  output logic      serialIn,
  output logic      pauseN
);
  // Select starts low so the first command comes without a fall
  initial begin
    serialClock = 1'b0;
    selectN     = 1'b0;
    serialIn    = 1'b0;
    pauseN      = 1'b1;
  end

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  // A select fall opens every command after the first; pause stays high meanwhile
  task automatic sel();
    ticks(1);
    selectN = 1'b0;
    ticks(4);
  endtask

  // Deselect after the last rise; data line no longer holds its value
  task automatic desel();
    ticks(4);
    selectN  = 1'b1;
    serialIn = ~serialIn;
    ticks(8);
  endtask

  // Pause with the clock low; clock and data wiggle while paused
  task automatic hold();
    pauseN = 1'b0;
    ticks(4);
    repeat (2) begin
      serialClock = 1'b1;
      serialIn    = ~serialIn;
      ticks(4);
      serialClock = 1'b0;
      ticks(4);
    end
    pauseN = 1'b1;
  endtask

  // MSB first, data set with the clock low, read bit taken at the rise
  task automatic xfer(input logic [7:0] tx, input int n, input int pauseAt,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (i == pauseAt) hold();
      serialIn = tx[i];
      ticks(4);
      rx[i] = serialOutEn ? serialOut : 1'bx;
      serialClock = 1'b1;
      ticks(4);
      serialClock = 1'b0;
    end
  endtask
endmodule

// [sim/spi_eeprom_protect_ctrl_tb.sv]
`timescale 1ns/1ps
module spi_eeprom_protect_ctrl_tb;
  import sepc_pkg::*;
  localparam int WC = 300;
  logic              clk = 1'b0;
  logic              reset, serialClock, selectN, serialIn, pauseN;
  logic              writeGuardN, serialOut, serialOutEn;
  logic              arrWrValid, arrWrReady, writeBusy;
  logic [ADDR_W-1:0] arrRdAddr, arrWrAddr;
  logic [7:0]        arrRdData, arrWrData, r;
  logic [7:0]        mem [0:4095];
  logic [7:0]        txq[$], rxq[$];
  int                n_mismatch = 0, tests_run = 0, cyc = 0;

  always #5 clk = ~clk;
  assign arrRdData = mem[arrRdAddr];
  always @(posedge clk) begin
    if (arrWrValid && arrWrReady) mem[arrWrAddr] <= arrWrData;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end

  sepc_spi_master m (.clk(clk), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .serialClock(serialClock),
    .selectN(selectN), .serialIn(serialIn), .pauseN(pauseN));

  sepc_ctrl #(.WRITE_CYCLES_P(WC)) dut (.clk(clk), .reset(reset),
    .serialClock(serialClock), .selectN(selectN), .serialIn(serialIn),
    .pauseN(pauseN), .writeGuardN(writeGuardN), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .arrRdAddr(arrRdAddr),
    .arrRdData(arrRdData), .arrWrValid(arrWrValid),
    .arrWrReady(arrWrReady), .arrWrAddr(arrWrAddr),
    .arrWrData(arrWrData), .writeBusy(writeBusy));

  function automatic logic [7:0] orig(input logic [11:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic op(input bit doPause, input int lastBits);
    rxq = {};
    m.sel();
    foreach (txq[k]) begin
      m.xfer(txq[k], (k == txq.size() - 1) ? lastBits : 8,
             (doPause && k == 3) ? 5 : -1, r);
      rxq.push_back(r);
    end
    m.desel();
  endtask

  task automatic cmd1(input logic [7:0] opc);
    txq = '{opc};
    op(1'b0, 8);
  endtask

  task automatic cmd_read_status(input logic [7:0] exp);
    txq = '{OP_READ_STAT, 8'h00, 8'h00};
    op(1'b0, 8);
    chk(rxq[1], exp);
    chk(rxq[2], exp);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000 && writeBusy !== 1'b0; i++) m.ticks(1);
    chk({7'h00, writeBusy}, 8'h00);
  endtask

  task automatic cmd_write_status(input logic [7:0] v, input logic expBusy);
    cmd1(OP_SET_LATCH);
    txq = '{OP_WRITE_STAT, v};
    op(1'b0, 8);
    chk({7'h00, writeBusy}, {7'h00, expBusy});
    if (expBusy) begin
      cmd_read_status(ST_BUSY_VIEW);
      wait_idle();
    end
  endtask

  task automatic t_powerup();
    m.xfer(OP_READ_STAT, 8, -1, r);
    m.xfer(8'h00, 8, -1, r);
    chk({7'h00, serialOutEn}, 8'h00);
    m.desel();
    chk({7'h00, serialOutEn}, 8'h00);
  endtask

  task automatic t_latch();
    cmd_read_status(8'h00);
    cmd1(OP_SET_LATCH);
    cmd_read_status(8'h02);
    cmd1(OP_CLR_LATCH);
    cmd_read_status(8'h00);
    txq = '{OP_SET_LATCH, OP_WRITE_STAT, 8'h80};
    op(1'b0, 8);
    chk({7'h00, writeBusy}, 8'h00);
    cmd_read_status(8'h02);
    cmd1(OP_CLR_LATCH);
  endtask

  task automatic t_guard();
    cmd_write_status(8'h84, 1'b1);
    cmd_read_status(8'h84);
    writeGuardN = 1'b0;
    cmd_write_status(8'h00, 1'b0);
    cmd_read_status(8'h86);
    writeGuardN = 1'b1;
    m.sel();
    m.xfer(OP_WRITE_STAT, 8, -1, r);
    fork
      m.xfer(8'h00, 8, -1, r);
      begin
        m.ticks(20);
        writeGuardN = 1'b0;
        m.ticks(12);
        writeGuardN = 1'b1;
      end
    join
    m.desel();
    chk({7'h00, writeBusy}, 8'h00);
    writeGuardN = 1'b1;
    cmd_read_status(8'h86);
    cmd_write_status(8'h00, 1'b1);
    writeGuardN = 1'b0;
    cmd_write_status(8'h08, 1'b1);
    cmd_read_status(8'h08);
    writeGuardN = 1'b1;
  endtask

  task automatic t_program();
    txq = '{OP_PROGRAM, 8'h01, 8'h00, 8'h55};
    op(1'b0, 8);
    chk({7'h00, writeBusy}, 8'h00);
    cmd1(OP_SET_LATCH);
    op(1'b0, 5);
    chk({7'h00, writeBusy}, 8'h00);
    chk(mem[12'h100], orig(12'h100));
    arrWrReady = 1'b0;
    txq = '{OP_PROGRAM, 8'h07, 8'hFE, 8'hA1, 8'hA2, 8'hA3};
    op(1'b0, 8);
    chk({7'h00, writeBusy}, 8'h01);
    chk(mem[12'h7FE], orig(12'h7FE));
    arrWrReady = 1'b1;
    wait_idle();
    chk(mem[12'h7FE], 8'hA1);
    chk(mem[12'h7FF], 8'hA2);
    chk(mem[12'h7E0], 8'hA3);
    cmd_read_status(8'h08);
    cmd1(OP_SET_LATCH);
    txq = '{OP_PROGRAM, 8'h08, 8'h00, 8'h99};
    op(1'b0, 8);
    wait_idle();
    chk(mem[12'h800], orig(12'h800));
  endtask

  task automatic t_fetch();
    txq = '{OP_FETCH, 8'hFF, 8'hFF, 8'h00, 8'h00};
    op(1'b1, 8);
    chk(rxq[3], orig(12'hFFF));
    chk(rxq[4], orig(12'h000));
    txq = '{OP_FETCH, 8'h00, 8'h08, 8'h00};
    op(1'b0, 8);
    chk(rxq[3], orig(12'h008));
    chk({7'h00, serialOutEn}, 8'h00);
  endtask

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = orig(i[11:0]);
    reset       = 1'b1;
    writeGuardN = 1'b1;
    arrWrReady  = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_powerup();
    t_latch();
    t_guard();
    t_program();
    t_fetch();
    test_done();
  end
endmodule
